// *** rtl/nvsr_pkg.sv ***
// package: constants, types and command decoding for the nvsram host controller
package nvsr_pkg;

    // ****************************************************************
    // bus widths
    // ****************************************************************
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CMD_MATCH_W = 13;    // device compares only these low bits
    localparam int CMD_STEPS = 6;
    localparam int TIMER_W = 24;

    // ****************************************************************
    // timing, in printed units, and derived cycle counts
    // ****************************************************************
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int ACCESS_NS = 45;              // slowest grade read/write cycle
    localparam int POWERUP_RESTORE_MS = 40;     // powerup_restore_duration
    localparam int NV_COPY_COMM_US = 12_500;    // nv_copy_duration, commercial
    localparam int NV_COPY_IND_US = 15_000;     // nv_copy_duration, industrial
    localparam int RECALL_US = 100;
    localparam int SYNC_STAGES = 2;
    // least times round up to whole cycles
    localparam int ACCESS_CYC = (ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int POWERUP_CYC =
        (POWERUP_RESTORE_MS * 1_000_000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int NV_COPY_COMM_CYC =
        (NV_COPY_COMM_US * 1_000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int NV_COPY_IND_CYC =
        (NV_COPY_IND_US * 1_000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int RECALL_CYC = (RECALL_US * 1_000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // ****************************************************************
    // command address sequence
    // ****************************************************************
    localparam logic [12:0] CMD_ADDR_0 = 13'h0E38;
    localparam logic [12:0] CMD_ADDR_1 = 13'h11C7; // 0x31C7 cut to 13 bits
    localparam logic [12:0] CMD_ADDR_2 = 13'h03E0;
    localparam logic [12:0] CMD_ADDR_3 = 13'h1C1F; // 0x3C1F cut to 13 bits
    localparam logic [12:0] CMD_ADDR_4 = 13'h103F; // 0x303F cut to 13 bits
    localparam logic [12:0] CMD_ADDR_STORE = 13'h0FC0;
    localparam logic [12:0] CMD_ADDR_RECALL = 13'h0C63;
    localparam logic [1:0] ADDR_UPPER_FILL = 2'h0;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_STORE,
        OP_RECALL
    } nvsr_op_type;

    typedef struct packed {
        nvsr_op_type op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } nvsr_req_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic chip_sel_n;
        logic write_n;
        logic out_en_n;
    } nvsr_pins_type;

    // address of one step of the store or recall sequence
    function automatic logic [CMD_MATCH_W-1:0] cmd_addr(input logic [2:0] step,
                                                        input logic recall);
        logic [CMD_MATCH_W-1:0] a;
        a = CMD_ADDR_0;
        case (step)
            3'h0: a = CMD_ADDR_0;
            3'h1: a = CMD_ADDR_1;
            3'h2: a = CMD_ADDR_2;
            3'h3: a = CMD_ADDR_3;
            3'h4: a = CMD_ADDR_4;
            default: a = recall ? CMD_ADDR_RECALL : CMD_ADDR_STORE;
        endcase
        return a;
    endfunction

endpackage

// *** rtl/nvsr_timer.sv ***
// file: down-counting wait timer used for pin phases and nonvolatile waits
`timescale 1ns/10ps
`default_nettype none

module nvsr_timer #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    // status
    output logic expired
);

    logic [WIDTH-1:0] count_q;

    // ****************************************************************
    // counter
    // ****************************************************************
    // load wins over counting so a new phase never inherits a stale count
    always_ff @(posedge clock) begin
        if (reset) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_value;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    assign expired = (count_q == '0) && !load;

endmodule
`default_nettype wire

// *** rtl/nvsr_host.sv ***
// file: host controller driving the nvsram access pins
`timescale 1ns/10ps
`default_nettype none

module nvsr_host #(
    parameter int POWERUP_WAIT = nvsr_pkg::POWERUP_CYC,
    parameter int STORE_WAIT = nvsr_pkg::NV_COPY_IND_CYC,
    parameter int RECALL_WAIT = nvsr_pkg::RECALL_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire nvsr_pkg::nvsr_req_type req,
    // user answer
    output logic resp_valid,
    output logic [nvsr_pkg::DATA_W-1:0] resp_data,
    output logic busy,
    // memory pins
    output nvsr_pkg::nvsr_pins_type pins,
    input wire logic [nvsr_pkg::DATA_W-1:0] dq_in,
    output logic [nvsr_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic hw_store_busy_n_in,
    output logic hw_store_busy_n_out,
    output logic hw_store_busy_n_oe
);

    localparam int TW = nvsr_pkg::TIMER_W;

    typedef enum logic [2:0] {
        ST_BOOT,
        ST_POWER,
        ST_IDLE,
        ST_SETUP,
        ST_ACCESS,
        ST_RELEASE,
        ST_NVWAIT
    } nvsr_state_type;

    nvsr_state_type state_q;
    nvsr_pkg::nvsr_op_type op_q;
    nvsr_pkg::nvsr_pins_type pins_q;
    logic [nvsr_pkg::DATA_W-1:0] wdata_q;
    logic [nvsr_pkg::ADDR_W-1:0] req_addr_q;
    logic [nvsr_pkg::DATA_W-1:0] dq_meta_q;
    logic [nvsr_pkg::DATA_W-1:0] dq_sync_q;
    logic hsb_meta_q;
    logic hsb_sync_q;
    logic [2:0] step_q;
    logic cmd_q;
    logic dq_oe_q;
    logic resp_valid_q;
    logic [nvsr_pkg::DATA_W-1:0] resp_data_q;
    logic timer_load;
    logic [TW-1:0] timer_value;
    logic timer_done;
    logic last_step;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // data and busy come from an unclocked part, two stages each
    always_ff @(posedge clock) begin
        if (reset) begin
            dq_meta_q <= '0;
            dq_sync_q <= '0;
            hsb_meta_q <= 1'b0;
            hsb_sync_q <= 1'b0;
        end else begin
            dq_meta_q <= dq_in;
            dq_sync_q <= dq_meta_q;
            hsb_meta_q <= hw_store_busy_n_in;
            hsb_sync_q <= hsb_meta_q;
        end
    end

    // ****************************************************************
    // phase timer
    // ****************************************************************
    nvsr_timer #(
        .WIDTH(TW)
    ) u_timer (
        .clock(clock),
        .reset(reset),
        .load(timer_load),
        .load_value(timer_value),
        .expired(timer_done)
    );

    assign last_step = cmd_q && (step_q == 3'(nvsr_pkg::CMD_STEPS - 1));

    // timer loads only before the power, access and nonvolatile waits; access time includes sync delay
    always_comb begin
        timer_load = 1'b0;
        timer_value = '0;
        unique case (state_q)
            ST_BOOT: begin
                timer_load = 1'b1;
                timer_value = TW'(POWERUP_WAIT);
            end
            ST_SETUP: begin
                timer_load = 1'b1;
                timer_value = TW'(nvsr_pkg::ACCESS_CYC + nvsr_pkg::SYNC_STAGES);
            end
            ST_RELEASE: begin
                timer_load = last_step;
                // worst grade copy time, recall time otherwise
                timer_value = (op_q == nvsr_pkg::OP_RECALL) ? TW'(RECALL_WAIT) :
                              TW'(STORE_WAIT);
            end
            ST_POWER, ST_IDLE, ST_ACCESS, ST_NVWAIT: begin
                timer_load = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // a busy device ignores accesses, so hold off while busy is low
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ST_BOOT;
            op_q <= nvsr_pkg::OP_READ;
            wdata_q <= '0;
            step_q <= '0;
            cmd_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_BOOT: state_q <= ST_POWER;
                ST_POWER: begin
                    if (timer_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (req_valid && hsb_sync_q) begin
                        op_q <= req.op;
                        wdata_q <= req.wdata;
                        step_q <= '0;
                        // store is always issued, even with no write since
                        cmd_q <= (req.op == nvsr_pkg::OP_STORE) ||
                                 (req.op == nvsr_pkg::OP_RECALL);
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: state_q <= ST_ACCESS;
                ST_ACCESS: begin
                    if (timer_done) begin
                        state_q <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    if (last_step) begin
                        state_q <= ST_NVWAIT;
                    end else if (cmd_q) begin
                        step_q <= step_q + 3'h1;
                        state_q <= ST_SETUP;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_NVWAIT: begin
                    if (timer_done) begin
                        cmd_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // pin drive
    // ****************************************************************
    // select and strobe fall together on writes so the device floats
    always_ff @(posedge clock) begin
        if (reset) begin
            pins_q <= '{addr: '0, chip_sel_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1};
            dq_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_SETUP: begin
                    // upper bits are unused by command matching
                    pins_q.addr <= cmd_q ?
                        {nvsr_pkg::ADDR_UPPER_FILL, nvsr_pkg::cmd_addr(step_q,
                            op_q == nvsr_pkg::OP_RECALL)} : req_addr_q;
                    pins_q.chip_sel_n <= 1'b0;
                    pins_q.write_n <= (op_q != nvsr_pkg::OP_WRITE);
                    // last command access drives no data, so leave output off
                    pins_q.out_en_n <= (op_q == nvsr_pkg::OP_WRITE) || last_step;
                    dq_oe_q <= (op_q == nvsr_pkg::OP_WRITE);
                end
                ST_ACCESS: begin
                    if (timer_done) begin
                        pins_q.chip_sel_n <= 1'b1;
                        pins_q.write_n <= 1'b1;
                        pins_q.out_en_n <= 1'b1;
                    end
                end
                ST_RELEASE: begin
                    dq_oe_q <= 1'b0; // data held one cycle past the strobe
                end
                ST_BOOT, ST_POWER, ST_IDLE, ST_NVWAIT: begin
                    pins_q.chip_sel_n <= 1'b1;
                end
            endcase
        end
    end

    // address of a plain access, caught when the request is taken
    always_ff @(posedge clock) begin
        if (reset) begin
            req_addr_q <= '0;
        end else if (state_q == ST_IDLE && req_valid && hsb_sync_q) begin
            req_addr_q <= req.addr;
        end
    end

    // ****************************************************************
    // answer
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            resp_valid_q <= 1'b0;
            resp_data_q <= '0;
        end else begin
            resp_valid_q <= ((state_q == ST_RELEASE) && !cmd_q) ||
                            ((state_q == ST_NVWAIT) && timer_done);
            if (state_q == ST_ACCESS && timer_done && op_q == nvsr_pkg::OP_READ) begin
                resp_data_q <= dq_sync_q;
            end
        end
    end

    assign req_ready = (state_q == ST_IDLE) && hsb_sync_q;
    assign busy = (state_q != ST_IDLE);
    assign resp_valid = resp_valid_q;
    assign resp_data = resp_data_q;
    assign pins = pins_q;
    assign dq_out = wdata_q;
    assign dq_oe = dq_oe_q;
    // busy line is only watched, never pulled low
    assign hw_store_busy_n_out = 1'b1;
    assign hw_store_busy_n_oe = 1'b0;

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence cmd_read_start;
        cmd_q && $fell(pins.chip_sel_n);
    endsequence

    sequence write_start;
        $fell(pins.write_n);
    endsequence

    read_strobe_high_a: assert property (@(posedge clock) disable iff (reset)
        (!pins.chip_sel_n && op_q == nvsr_pkg::OP_READ) |-> pins.write_n)
        else $error("write strobe low during a read");

    busy_line_free_a: assert property (@(posedge clock) disable iff (reset)
        !hw_store_busy_n_oe && hw_store_busy_n_out)
        else $error("hardware store line driven");

    cmd_only_reads_a: assert property (@(posedge clock) disable iff (reset)
        cmd_read_start |-> (pins.write_n && !dq_oe)[*8])
        else $error("command access not a plain read");

    cmd_addr_order_a: assert property (@(posedge clock) disable iff (reset)
        cmd_read_start |-> pins.addr[12:0] ==
            nvsr_pkg::cmd_addr(step_q, op_q == nvsr_pkg::OP_RECALL))
        else $error("command address out of order");

    cmd_six_steps_a: assert property (@(posedge clock) disable iff (reset)
        (state_q == ST_NVWAIT) |-> step_q == 3'h5)
        else $error("nonvolatile wait before sixth read");

    write_pulse_len_a: assert property (@(posedge clock) disable iff (reset)
        write_start |-> (!pins.write_n && !pins.chip_sel_n)[*8])
        else $error("write pulse too short");

    nv_quiet_a: assert property (@(posedge clock) disable iff (reset)
        (state_q == ST_NVWAIT) |-> pins.chip_sel_n && !req_ready)
        else $error("access during nonvolatile wait");

    powerup_quiet_a: assert property (@(posedge clock) disable iff (reset)
        (state_q == ST_POWER) |-> pins.chip_sel_n && !req_ready)
        else $error("access before powerup restore");

endmodule
`default_nettype wire

// *** verif/nvsr_device_model.sv ***
// file: behavioural nvsram device answering the host controller's pins
`timescale 1ns/10ps
`default_nettype none

module nvsr_device_model #(
    parameter int POWERUP_CYC = 15,
    parameter int STORE_CYC = 25,
    parameter int RECALL_CYC = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // host pins
    input wire nvsr_pkg::nvsr_pins_type pins,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    // test control
    input wire logic hold_busy,
    input wire logic supply_low,
    // device answers
    output logic [7:0] dq_in,
    output logic hw_store_busy_n
);
    // ****************************************************************
    // state
    // ****************************************************************
    localparam logic [12:0] SEQ [0:4] = '{13'h0E38, 13'h11C7, 13'h03E0, 13'h1C1F, 13'h103F};
    localparam logic [12:0] FIN_STORE = 13'h0FC0;
    localparam logic [12:0] FIN_RECALL = 13'h0C63;
    logic [7:0] sram_q [0:32767];
    logic [7:0] nv_q [0:32767];
    int busy_cnt_q = 0;
    logic recall_q = 1'b0;
    logic modified_q = 1'b0;
    logic [2:0] step_q = 3'h0;
    logic sel_q = 1'b1;
    logic float_q = 1'b0;
    logic wr_q = 1'b0;
    logic [7:0] wd_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic [14:0] addr_q = 15'h0000;

    // ****************************************************************
    // behaviour, sampled on the host clock for simplicity
    // ****************************************************************
    // one process: array copies need blocking assignment anyway
    always @(posedge clock) begin
        if (reset) begin
            busy_cnt_q <= POWERUP_CYC;
            recall_q <= 1'b1;
            step_q <= 3'h0;
            modified_q <= 1'b0;
            sel_q <= 1'b1;
            wr_q <= 1'b0;
            float_q <= 1'b0;
            last_q <= 8'h00;
        end else begin
            sel_q <= pins.chip_sel_n;
            last_q <= dq_in;
            if (!pins.chip_sel_n) begin
                addr_q <= pins.addr;
                if (sel_q) begin
                    float_q <= !pins.write_n;
                    wr_q <= 1'b0;
                end
                if (!pins.write_n) begin
                    wr_q <= 1'b1;
                end
                if (dq_oe) begin
                    wd_q <= dq_out;
                end
            end
            if (busy_cnt_q != 0) begin
                busy_cnt_q <= busy_cnt_q - 1;
                if (busy_cnt_q == 1) begin
                    if (recall_q) sram_q = nv_q;
                    else nv_q = sram_q;
                    modified_q <= 1'b0;
                end
            end else if (supply_low) begin
                // automatic store only when something changed
                if (modified_q) begin
                    busy_cnt_q <= STORE_CYC;
                    recall_q <= 1'b0;
                end
            end else if (!sel_q && pins.chip_sel_n) begin
                if (wr_q) begin
                    sram_q[addr_q] = wd_q;
                    modified_q <= 1'b1;
                    step_q <= 3'h0;
                end else if (step_q == 3'h5 &&
                             (addr_q[12:0] == FIN_STORE || addr_q[12:0] == FIN_RECALL)) begin
                    // software store runs even when clean
                    busy_cnt_q <= (addr_q[12:0] == FIN_RECALL) ? RECALL_CYC : STORE_CYC;
                    recall_q <= (addr_q[12:0] == FIN_RECALL);
                    step_q <= 3'h0;
                end else if (step_q != 3'h5 && addr_q[12:0] == SEQ[step_q]) begin
                    step_q <= step_q + 3'h1;
                end else begin
                    step_q <= (addr_q[12:0] == SEQ[0]) ? 3'h1 : 3'h0;
                end
            end
        end
    end

    // read data; a released bus never repeats its last value
    always_comb begin
        if (!pins.chip_sel_n && !pins.out_en_n && pins.write_n && busy_cnt_q == 0 &&
            (sel_q || !float_q)) begin
            dq_in = sram_q[pins.addr];
        end else begin
            dq_in = ~last_q;
        end
    end

    // busy line low during any nonvolatile operation
    assign hw_store_busy_n = !(busy_cnt_q != 0 || hold_busy);

endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
// file: testbench for the nvsram host controller
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    // ****************************************************************
    // signals
    // ****************************************************************
    typedef struct packed {
        nvsr_pkg::nvsr_op_type op;
        logic [14:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } nvsr_row_type;
    logic clock, reset, req_valid, req_ready, resp_valid, busy, dq_oe;
    logic hsb_out, hsb_oe, hsb_wire, model_hsb, hold_busy, supply_low;
    logic [7:0] resp_data, dq_in, dq_out;
    nvsr_pkg::nvsr_req_type req;
    nvsr_pkg::nvsr_pins_type pins;
    nvsr_row_type rows [10];
    int errors, checked;

    // open-drain busy line: either party may pull it low
    assign hsb_wire = (hsb_oe && !hsb_out) ? 1'b0 : model_hsb;

    nvsr_host #(.POWERUP_WAIT(20), .STORE_WAIT(30), .RECALL_WAIT(10)) nvsr_host_inst (
        .clock(clock), .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .resp_valid(resp_valid), .resp_data(resp_data), .busy(busy), .pins(pins),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .hw_store_busy_n_in(hsb_wire),
        .hw_store_busy_n_out(hsb_out), .hw_store_busy_n_oe(hsb_oe));

    // model keeps its default times, all below the host's waits
    nvsr_device_model nvsr_device_model_inst (
        .clock(clock), .reset(reset), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
        .hold_busy(hold_busy), .supply_low(supply_low), .dq_in(dq_in),
        .hw_store_busy_n(model_hsb));

    // ****************************************************************
    // compare and request tasks
    // ****************************************************************
    task automatic check_flag(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_data(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held until the edge that takes it, then bounded wait
    task automatic run_req(input nvsr_row_type r);
        int n;
        @(posedge clock);
        #1;
        req_valid = 1'b1;
        req = '{op: r.op, addr: r.addr, wdata: r.wdata};
        n = 0;
        while (req_ready !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1;
            n++;
        end
        check_flag("resp_valid", 1'b1, resp_valid);
        if (r.op == nvsr_pkg::OP_READ) check_data("resp_data", r.exp, resp_data);
    endtask

    task automatic complete_run;
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ****************************************************************
    // pin monitor
    // ****************************************************************
    // op bit 1 marks store and recall, whose reads all need the strobe high
    always @(posedge clock) begin
        if (!reset) begin
            check_flag("busy_line_oe", 1'b0, hsb_oe);
            if (!pins.chip_sel_n && (!pins.out_en_n || req.op[1])) begin
                check_flag("write_n", 1'b1, pins.write_n);
            end
        end
    end

    // ****************************************************************
    // clock, watchdog, main sequence
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // whole run needs well under ten thousand cycles
    initial begin
        #200_000;
        errors++;
        complete_run();
    end

    initial begin
        errors = 0;
        checked = 0;
        reset = 1'b1;
        req_valid = 1'b0;
        req = '0;
        hold_busy = 1'b0;
        supply_low = 1'b0;
        rows = '{
            '{nvsr_pkg::OP_WRITE, 15'h0000, 8'h5A, 8'h00},
            '{nvsr_pkg::OP_WRITE, 15'h7FFF, 8'hC3, 8'h00},
            '{nvsr_pkg::OP_READ, 15'h0000, 8'h00, 8'h5A},
            '{nvsr_pkg::OP_READ, 15'h7FFF, 8'h00, 8'hC3},
            '{nvsr_pkg::OP_STORE, 15'h0000, 8'h00, 8'h00},
            '{nvsr_pkg::OP_WRITE, 15'h0000, 8'h11, 8'h00},
            '{nvsr_pkg::OP_READ, 15'h0000, 8'h00, 8'h11},
            '{nvsr_pkg::OP_RECALL, 15'h0000, 8'h00, 8'h00},
            '{nvsr_pkg::OP_READ, 15'h0000, 8'h00, 8'h5A},
            '{nvsr_pkg::OP_READ, 15'h7FFF, 8'h00, 8'hC3}};
        repeat (8) @(posedge clock);
        #1;
        // idle pin levels while reset holds
        check_flag("chip_sel_n", 1'b1, pins.chip_sel_n);
        check_flag("write_n", 1'b1, pins.write_n);
        check_flag("out_en_n", 1'b1, pins.out_en_n);
        check_flag("dq_oe", 1'b0, dq_oe);
        check_flag("busy", 1'b1, busy);
        check_flag("req_ready", 1'b0, req_ready);
        reset = 1'b0;
        // ordinary traffic, then store, overwrite, recall
        foreach (rows[i]) begin
            run_req(rows[i]);
        end
        // device holds busy: request must stall without touching the pins
        hold_busy = 1'b1;
        repeat (4) @(posedge clock);
        fork
            run_req(rows[3]);
            begin
                repeat (12) @(posedge clock);
                #1;
                check_flag("req_ready", 1'b0, req_ready);
                check_flag("chip_sel_n", 1'b1, pins.chip_sel_n);
                hold_busy = 1'b0;
            end
        join
        // a clean array is still stored by command
        run_req(rows[4]);
        run_req(rows[8]);
        // dirty array, then a supply dip: the device stores on its own and holds busy
        run_req(rows[5]);
        supply_low = 1'b1;
        @(posedge clock);
        #1;
        supply_low = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check_flag("req_ready", 1'b0, req_ready);
        // this write waits out the store, so only the restore can undo it
        run_req(rows[0]);
        // second reset mid-run: idle pins, then the restored byte must read back
        reset = 1'b1;
        repeat (8) @(posedge clock);
        #1;
        check_flag("busy", 1'b1, busy);
        check_flag("chip_sel_n", 1'b1, pins.chip_sel_n);
        reset = 1'b0;
        run_req(rows[6]);
        complete_run();
    end

endmodule

`default_nettype wire
